// [verilog/fucr_top.sv]
// Firmware update, calibration window and source selection register block
`timescale 1ns/10ps
module fucr_top #(
  parameter int unsigned IMAGE_SIZE = fucr_pkg::IMAGE_BYTES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Byte register port from the serial slave engine
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Chained device presence pins
  input wire logic first_slave_present,
  input wire logic second_slave_present,
  // Reporting and update status
  output logic [1:0] source_select,
  output logic update_active,
  output logic image_complete,
  output logic active_partition,
  output logic reboot_request,
  output logic swap_failed,
  // Image byte stream toward persistent storage
  output logic image_byte_valid,
  output logic [7:0] image_byte,
  output logic [15:0] image_byte_addr
);

  localparam logic [15:0] LAST_INDEX = 16'(IMAGE_SIZE - 1);

  fucr_pkg::fucr_state_t state;
  fucr_pkg::fucr_state_t next_state;

  logic [7:0] na;
  logic [1:0] pres_meta;
  logic [1:0] pres_sync;
  logic [7:0] payload_byte;
  logic [7:0] download_byte;
  logic [31:0] cal_window;
  logic [7:0] fetch_index;
  logic [7:0] store_index;
  logic [15:0] next_index;
  logic ctrl_wr;
  logic begin_req;
  logic abort_req;
  logic swap_req;
  logic img_wr;
  logic crc_good;
  logic check_done;
  logic [7:0] ctrl_view;
  logic [7:0] sel_view;
  logic [7:0] next_rdata;

  fucr_cal_if cal ();
  fucr_crc_if crc ();

  // Calibration store and image check engine
  fucr_cal_mem #(
    .DEPTH(fucr_pkg::CAL_DEPTH)
  ) u_cal_mem (
    .clk(clk),
    .srst(srst),
    .cal(cal)
  );

  fucr_crc u_crc (
    .clk(clk),
    .srst(srst),
    .crc(crc)
  );

  // The update registers also answer in the upper alias window
  always_comb begin
    if (reg_addr[7:2] == fucr_pkg::ADDR_ALIAS_BASE[7:2]) begin
      na = {fucr_pkg::ADDR_CTRL[7:2], reg_addr[1:0]};
    end else begin
      na = reg_addr;
    end
  end

  // Presence pins come from other devices, so two flops before any use
  always_ff @(posedge clk) begin
    if (srst) begin
      pres_meta <= 2'h0;
      pres_sync <= 2'h0;
    end else begin
      pres_meta <= {second_slave_present, first_slave_present};
      pres_sync <= pres_meta;
    end
  end

  // Control register write decode; abort outranks begin and swap
  assign ctrl_wr = reg_wr && (na == fucr_pkg::ADDR_CTRL);
  assign abort_req = ctrl_wr && reg_wdata[fucr_pkg::CTRL_ABORT_BIT];
  assign begin_req = ctrl_wr && reg_wdata[fucr_pkg::CTRL_BEGIN_BIT] && !abort_req;
  assign swap_req = ctrl_wr && reg_wdata[fucr_pkg::CTRL_SWAP_BIT] && !abort_req
                    && !begin_req;

  // Image bytes count only while loading; extra bytes past the end are dropped
  assign img_wr = reg_wr && (state == fucr_pkg::ST_LOAD)
                  && ((na == fucr_pkg::ADDR_PAYLOAD) || (na == fucr_pkg::ADDR_DOWNLOAD));

  assign crc_good = (crc.value == fucr_pkg::CRC_RESIDUE);

  // A begin or abort landing in the check cycle cancels the swap outcome
  assign check_done = (state == fucr_pkg::ST_CHECK) && !abort_req && !begin_req;

  // CRC runs on the fly so the swap check costs a single cycle
  assign crc.init = begin_req;
  assign crc.en = img_wr;
  assign crc.data = reg_wdata;

  // Calibration requests go straight to the store with the written index
  assign cal.fetch = reg_wr && (na == fucr_pkg::ADDR_FETCH);
  assign cal.store = reg_wr && (na == fucr_pkg::ADDR_STORE);
  assign cal.index = reg_wdata;
  assign cal.wr_word = cal_window;

  // Update sequencer transitions
  always_comb begin
    next_state = state;
    case (state)
      fucr_pkg::ST_IDLE: begin
        if (begin_req) begin
          next_state = fucr_pkg::ST_LOAD;
        end
      end
      fucr_pkg::ST_LOAD: begin
        if (abort_req) begin
          next_state = fucr_pkg::ST_IDLE;
        end else if (begin_req) begin
          next_state = fucr_pkg::ST_LOAD;
        end else if (img_wr && (next_index == LAST_INDEX)) begin
          next_state = fucr_pkg::ST_FULL;
        end
      end
      fucr_pkg::ST_FULL: begin
        if (abort_req) begin
          next_state = fucr_pkg::ST_IDLE;
        end else if (begin_req) begin
          next_state = fucr_pkg::ST_LOAD;
        end else if (swap_req) begin
          next_state = fucr_pkg::ST_CHECK;
        end
      end
      fucr_pkg::ST_CHECK: begin
        if (abort_req) begin
          next_state = fucr_pkg::ST_IDLE;
        end else if (begin_req) begin
          next_state = fucr_pkg::ST_LOAD;
        end else if (crc_good) begin
          next_state = fucr_pkg::ST_IDLE;
        end else begin
          next_state = fucr_pkg::ST_FULL;
        end
      end
      default: begin
        next_state = fucr_pkg::ST_IDLE;
      end
    endcase
  end

  // Sequencer state register
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= fucr_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Next expected byte index; cleared by begin and abort
  always_ff @(posedge clk) begin
    if (srst) begin
      next_index <= 16'h0000;
    end else if (abort_req || begin_req) begin
      next_index <= 16'h0000;
    end else if (img_wr) begin
      next_index <= next_index + 16'h0001;
    end
  end

  // Accepted bytes are forwarded with their position in the image
  always_ff @(posedge clk) begin
    if (srst) begin
      image_byte_valid <= 1'b0;
      image_byte <= 8'h00;
      image_byte_addr <= 16'h0000;
    end else begin
      image_byte_valid <= img_wr;
      if (img_wr) begin
        image_byte <= reg_wdata;
        image_byte_addr <= next_index;
      end
    end
  end

  // Partition flips only on a clean check; a failed check leaves it alone
  always_ff @(posedge clk) begin
    if (srst) begin
      active_partition <= 1'b0;
      reboot_request <= 1'b0;
    end else begin
      reboot_request <= 1'b0;
      if (check_done && crc_good) begin
        active_partition <= ~active_partition;
        reboot_request <= 1'b1;
      end
    end
  end

  // Swap refusal flag: set on bad CRC or a swap in any state other than full
  always_ff @(posedge clk) begin
    if (srst) begin
      swap_failed <= 1'b0;
    end else if (check_done && !crc_good) begin
      swap_failed <= 1'b1;
    end else if (swap_req && (state != fucr_pkg::ST_FULL)) begin
      swap_failed <= 1'b1;
    end else if (begin_req) begin
      swap_failed <= 1'b0;
    end
  end

  // Payload and download registers keep the last byte for read-back
  always_ff @(posedge clk) begin
    if (srst) begin
      payload_byte <= fucr_pkg::PAYLOAD_RESET;
      download_byte <= 8'h00;
    end else if (reg_wr && (na == fucr_pkg::ADDR_PAYLOAD)) begin
      payload_byte <= reg_wdata;
    end else if (reg_wr && (na == fucr_pkg::ADDR_DOWNLOAD)) begin
      download_byte <= reg_wdata;
    end
  end

  // Source selection; the unused code 3 is refused and the old value kept
  always_ff @(posedge clk) begin
    if (srst) begin
      source_select <= fucr_pkg::SRC_MASTER;
    end else if (reg_wr && (na == fucr_pkg::ADDR_SRC_SEL)
                 && (reg_wdata[1:0] != 2'h3)) begin
      source_select <= reg_wdata[1:0];
    end
  end

  // Calibration window: a host byte write lands after a fetch answer in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      cal_window <= fucr_pkg::CAL_BLANK;
    end else begin
      if (cal.rd_valid) begin
        cal_window <= cal.rd_word;
      end
      if (reg_wr) begin
        case (na)
          fucr_pkg::ADDR_CAL_W0: cal_window[7:0] <= reg_wdata;
          fucr_pkg::ADDR_CAL_W1: cal_window[15:8] <= reg_wdata;
          fucr_pkg::ADDR_CAL_W2: cal_window[23:16] <= reg_wdata;
          fucr_pkg::ADDR_CAL_W3: cal_window[31:24] <= reg_wdata;
          default: begin
          end
        endcase
      end
    end
  end

  // Sub-address registers read back the last index written
  always_ff @(posedge clk) begin
    if (srst) begin
      fetch_index <= 8'h00;
      store_index <= 8'h00;
    end else begin
      if (cal.fetch) begin
        fetch_index <= reg_wdata;
      end
      if (cal.store) begin
        store_index <= reg_wdata;
      end
    end
  end

  // Status views; abort and reserved bits always read zero
  always_comb begin
    ctrl_view = 8'h00;
    ctrl_view[fucr_pkg::CTRL_BEGIN_BIT] = update_active;
    ctrl_view[fucr_pkg::CTRL_COMPLETE_BIT] = image_complete;
    ctrl_view[fucr_pkg::CTRL_SWAP_BIT] = active_partition;
    sel_view = {6'h00, source_select};
    sel_view[fucr_pkg::SEL_FIRST_BIT] = pres_sync[0];
    sel_view[fucr_pkg::SEL_SECOND_BIT] = pres_sync[1];
  end

  // Session status outputs follow the sequencer
  assign update_active = (state != fucr_pkg::ST_IDLE);
  assign image_complete = (state == fucr_pkg::ST_FULL) || (state == fucr_pkg::ST_CHECK);

  // Read multiplexer; unmapped offsets read zero
  always_comb begin
    case (na)
      fucr_pkg::ADDR_PAYLOAD: next_rdata = payload_byte;
      fucr_pkg::ADDR_SRC_SEL: next_rdata = sel_view;
      fucr_pkg::ADDR_CAL_W0: next_rdata = cal_window[7:0];
      fucr_pkg::ADDR_CAL_W1: next_rdata = cal_window[15:8];
      fucr_pkg::ADDR_CAL_W2: next_rdata = cal_window[23:16];
      fucr_pkg::ADDR_CAL_W3: next_rdata = cal_window[31:24];
      fucr_pkg::ADDR_FETCH: next_rdata = fetch_index;
      fucr_pkg::ADDR_STORE: next_rdata = store_index;
      fucr_pkg::ADDR_CTRL: next_rdata = ctrl_view;
      fucr_pkg::ADDR_IDX_HI: next_rdata = next_index[15:8];
      fucr_pkg::ADDR_IDX_LO: next_rdata = next_index[7:0];
      fucr_pkg::ADDR_DOWNLOAD: next_rdata = download_byte;
      default: next_rdata = 8'h00;
    endcase
  end

  // Read data is registered; the value is sampled on the read strobe edge
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

endmodule : fucr_top

// [verilog/fucr_pkg.sv]
// Constants and types shared by the firmware update and calibration register block
package fucr_pkg;

  // Register offsets on the byte register port
  localparam logic [7:0] ADDR_PAYLOAD = 8'h4B;
  localparam logic [7:0] ADDR_SRC_SEL = 8'h4F;
  localparam logic [7:0] ADDR_CAL_W0 = 8'h50;
  localparam logic [7:0] ADDR_CAL_W1 = 8'h51;
  localparam logic [7:0] ADDR_CAL_W2 = 8'h52;
  localparam logic [7:0] ADDR_CAL_W3 = 8'h53;
  localparam logic [7:0] ADDR_FETCH = 8'h54;
  localparam logic [7:0] ADDR_STORE = 8'h55;
  localparam logic [7:0] ADDR_CTRL = 8'h60;
  localparam logic [7:0] ADDR_IDX_HI = 8'h61;
  localparam logic [7:0] ADDR_IDX_LO = 8'h62;
  localparam logic [7:0] ADDR_DOWNLOAD = 8'h63;
  // Upper alias window of the update registers, 0xE0 to 0xE3
  localparam logic [7:0] ADDR_ALIAS_BASE = 8'hE0;

  // Update control field positions
  localparam int CTRL_BEGIN_BIT = 7;
  localparam int CTRL_ABORT_BIT = 6;
  localparam int CTRL_COMPLETE_BIT = 5;
  localparam int CTRL_SWAP_BIT = 3;

  // Source selection fields and codes
  localparam int SEL_FIRST_BIT = 4;
  localparam int SEL_SECOND_BIT = 5;
  localparam logic [1:0] SRC_MASTER = 2'h0;
  localparam logic [1:0] SRC_FIRST = 2'h1;
  localparam logic [1:0] SRC_SECOND = 2'h2;

  // Reset values
  localparam logic [7:0] PAYLOAD_RESET = 8'h00;
  localparam logic [31:0] CAL_BLANK = 32'hFFFFFFFF;

  // Image size, 56k bytes
  localparam int unsigned IMAGE_BYTES = 56 * 1024;
  localparam int CAL_DEPTH = 256;

  // Reflected CRC-32 of the image including its trailing check word
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;

  // Update sequencer states, Gray along idle, load, full, check
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_FULL = 2'b11,
    ST_CHECK = 2'b10
  } fucr_state_t;

endpackage : fucr_pkg

// [verilog/fucr_ifs.sv]
// Interfaces between the register block and its CRC engine and calibration store
`timescale 1ns/10ps
interface fucr_cal_if;
  logic fetch;
  logic store;
  logic [7:0] index;
  logic [31:0] wr_word;
  logic [31:0] rd_word;
  logic rd_valid;
  modport ctrl (output fetch, output store, output index, output wr_word,
                input rd_word, input rd_valid);
  modport mem (input fetch, input store, input index, input wr_word,
               output rd_word, output rd_valid);
endinterface : fucr_cal_if

interface fucr_crc_if;
  logic init;
  logic en;
  logic [7:0] data;
  logic [31:0] value;
  modport user (output init, output en, output data, input value);
  modport engine (input init, input en, input data, output value);
endinterface : fucr_crc_if

// [verilog/fucr_crc.sv]
// Byte-serial CRC-32 engine over the downloaded image
`timescale 1ns/10ps
module fucr_crc (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Engine side of the CRC carrier
  fucr_crc_if.engine crc
);

  logic [31:0] next_crc;

  // One byte folded in per enabled cycle, LSB first
  always_comb begin
    next_crc = crc.value ^ {24'h000000, crc.data};
    for (int i = 0; i < 8; i++) begin
      next_crc = next_crc[0] ? ((next_crc >> 1) ^ fucr_pkg::CRC_POLY) : (next_crc >> 1);
    end
  end

  // Init wins over a byte so a restarted session never mixes images
  always_ff @(posedge clk) begin
    if (srst || crc.init) begin
      crc.value <= fucr_pkg::CRC_INIT;
    end else if (crc.en) begin
      crc.value <= next_crc;
    end
  end

endmodule : fucr_crc

// [verilog/fucr_cal_mem.sv]
// Calibration word store addressed by sub-address; reset clears the written bits so every entry reads blank
`timescale 1ns/10ps
module fucr_cal_mem #(
  parameter int DEPTH = fucr_pkg::CAL_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Store side of the calibration carrier
  fucr_cal_if.mem cal
);

  localparam int AW = $clog2(DEPTH);

  logic [31:0] words [DEPTH];
  logic [DEPTH-1:0] written;
  logic [AW-1:0] idx;

  assign idx = cal.index[AW-1:0];

  // Array is not reset; the written bits make unused entries read blank
  always_ff @(posedge clk) begin
    if (cal.store) begin
      words[idx] <= cal.wr_word;
    end
  end

  // Tracks which sub-addresses hold a stored word
  always_ff @(posedge clk) begin
    if (srst) begin
      written <= '0;
    end else if (cal.store) begin
      written[idx] <= 1'b1;
    end
  end

  // Fetch answer one cycle after the request
  always_ff @(posedge clk) begin
    if (srst) begin
      cal.rd_word <= fucr_pkg::CAL_BLANK;
      cal.rd_valid <= 1'b0;
    end else begin
      cal.rd_valid <= cal.fetch;
      if (cal.fetch) begin
        cal.rd_word <= written[idx] ? words[idx] : fucr_pkg::CAL_BLANK;
      end
    end
  end

endmodule : fucr_cal_mem

// [tb/fucr_host.sv]
// Host register master model on the block's byte register port
`timescale 1ns/10ps
module fucr_host (
  // Clock
  input wire logic clk,
  // Register requests
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial begin
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // One request per call; the spare edge keeps each strobe assigned once a step
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= ~w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'h0;
    reg_rd <= 1'h0;
    // Released lines carry no stale value
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : xfer

  // Control writes never touch the reserved bits
  task automatic ctrl(input logic [7:0] d);
    xfer(1'h1, fucr_pkg::ADDR_CTRL, d & 8'hC8);
  endtask : ctrl
endmodule : fucr_host

// [tb/fucr_properties.sv]
// Concurrent checks on the register block's top-level ports
`timescale 1ns/10ps
module fucr_checker #(
  parameter int unsigned IMAGE_SIZE = fucr_pkg::IMAGE_BYTES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rvalid,
  input wire logic [1:0] source_select,
  // Update status and image stream
  input wire logic update_active,
  input wire logic image_complete,
  input wire logic active_partition,
  input wire logic reboot_request,
  input wire logic swap_failed,
  input wire logic image_byte_valid,
  input wire logic [7:0] image_byte,
  input wire logic [15:0] image_byte_addr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic ctrl_wr;
  // Control writes through either window
  assign ctrl_wr = reg_wr && (reg_addr == 8'h60 || reg_addr == 8'hE0);

  property p_byte_src;
    image_byte_valid |-> $past(reg_wr) && $past(reg_wdata) == image_byte;
  endproperty
  a_byte_src: assert property (p_byte_src) else $error("image byte without write");
  property p_sel_legal;
    source_select != 2'h3;
  endproperty
  a_sel_legal: assert property (p_sel_legal) else $error("illegal source code");
  property p_rd_ans;
    reg_rd |=> reg_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read gave no answer");
  property p_sel_wr;
    reg_wr && reg_addr == 8'h4F && reg_wdata[1:0] != 2'h3 |=>
      source_select == $past(reg_wdata[1:0]);
  endproperty
  a_sel_wr: assert property (p_sel_wr) else $error("source select not taken");
  property p_begin;
    ctrl_wr && reg_wdata[7:6] == 2'h2 |=> update_active && !image_complete && !swap_failed;
  endproperty
  a_begin: assert property (p_begin) else $error("begin did not open session");
  property p_abort;
    ctrl_wr && reg_wdata[6] |=> !update_active && !image_complete;
  endproperty
  a_abort: assert property (p_abort) else $error("abort did not stop update");
  property p_complete;
    $rose(image_complete) |-> image_byte_addr == 16'(IMAGE_SIZE - 1);
  endproperty
  a_complete: assert property (p_complete) else $error("complete at wrong count");
  property p_swap_ans;
    ctrl_wr && reg_wdata[7:6] == 2'h0 && reg_wdata[3] && image_complete |->
      ##[1:4] (reboot_request || swap_failed);
  endproperty
  a_swap_ans: assert property (p_swap_ans) else $error("swap gave no answer");
  property p_reboot;
    reboot_request |-> !image_complete && active_partition != $past(active_partition);
  endproperty
  a_reboot: assert property (p_reboot) else $error("reboot without toggle");
  property p_fail_keep;
    $rose(swap_failed) |-> $stable(active_partition) && !reboot_request;
  endproperty
  a_fail_keep: assert property (p_fail_keep) else $error("failed swap moved partition");

  // Main scenarios reached
  c_reboot: cover property (reboot_request);
  c_fail: cover property ($rose(swap_failed));
  c_full: cover property ($rose(image_complete));
endmodule : fucr_checker

bind fucr_top fucr_checker #(.IMAGE_SIZE(IMAGE_SIZE)) chk_u (
  .clk(clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .source_select(source_select), .update_active(update_active),
  .image_complete(image_complete), .active_partition(active_partition),
  .reboot_request(reboot_request), .swap_failed(swap_failed),
  .image_byte_valid(image_byte_valid), .image_byte(image_byte),
  .image_byte_addr(image_byte_addr), .reg_rvalid(reg_rvalid)
);

// [tb/firmware_update_calib_regs_bench.sv]
// Self-checking bench for the firmware update and calibration register block
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin \
  check_count++; \
  if ((got) !== (ex)) begin \
    fail_count++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); \
  end \
end
module firmware_update_calib_regs_bench;
  localparam int unsigned IMG = 16;
  logic clk, srst, fp, sp, reg_wr, reg_rd, reg_rvalid, part;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, re;
  logic [1:0] source_select;
  logic update_active, image_complete, active_partition, reboot_request, swap_failed;
  logic image_byte_valid;
  logic [7:0] image_byte;
  logic [15:0] image_byte_addr;
  logic [23:0] ie;
  logic [7:0] rq [$];
  logic [23:0] iq [$];
  int check_count, fail_count;

  fucr_top #(.IMAGE_SIZE(IMG)) dut_u (
    .clk(clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .first_slave_present(fp), .second_slave_present(sp), .source_select(source_select),
    .update_active(update_active), .image_complete(image_complete),
    .active_partition(active_partition), .reboot_request(reboot_request),
    .swap_failed(swap_failed), .image_byte_valid(image_byte_valid),
    .image_byte(image_byte), .image_byte_addr(image_byte_addr)
  );
  fucr_host host_u (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata));

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report

  // Read with its expected answer noted first
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rq.push_back(e);
    host_u.xfer(1'h0, a, 8'h00);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_u.xfer(1'h1, a, d);
  endtask : wr
  task automatic img(input int k, input logic [7:0] b);
    iq.push_back({16'(k), b});
    wr(k[0] ? fucr_pkg::ADDR_DOWNLOAD : fucr_pkg::ADDR_PAYLOAD, b);
  endtask : img

  // Reflected CRC-32 step, bit by bit
  function automatic logic [31:0] crc8(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) r = r[0] ? (r >> 1) ^ fucr_pkg::CRC_POLY : r >> 1;
    return r;
  endfunction : crc8

  // Whole image in order, trailing check word, optionally corrupted
  task automatic load(input logic bad);
    logic [7:0] b [IMG];
    logic [31:0] c;
    c = fucr_pkg::CRC_INIT;
    for (int k = 0; k < IMG - 4; k++) begin
      b[k] = 8'($urandom);
      c = crc8(c, b[k]);
    end
    c = ~c;
    for (int k = 0; k < 4; k++) b[IMG - 4 + k] = c[8 * k +: 8];
    b[1] = b[1] ^ {7'h00, bad};
    host_u.ctrl(8'h80);
    rd(8'h61, 8'h00);
    for (int k = 0; k < IMG; k++) img(k, b[k]);
    wr(fucr_pkg::ADDR_DOWNLOAD, 8'h5A);
    rd(8'h62, 8'(IMG));
    rd(8'hE2, 8'(IMG));
    rd(8'h60, {4'hA, part, 3'h0});
  endtask : load

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // Answers taken off the queues as they appear
  always @(posedge clk) begin
    if (reg_rvalid) begin
      re = (rq.size() > 0) ? rq.pop_front() : 8'hXX;
      `CHK("rdata", re, reg_rdata)
    end
    if (image_byte_valid) begin
      ie = (iq.size() > 0) ? iq.pop_front() : 24'hXXXXXX;
      `CHK("image byte", ie, {image_byte_addr, image_byte})
    end
  end

  // Hang guard
  initial begin
    repeat (5000) @(posedge clk);
    `CHK("watchdog", 1'h0, 1'h1)
    final_report();
  end

  initial begin
    logic [15:0] rv [9];
    logic [31:0] w;
    logic [7:0] ix;
    int n;
    rv = '{16'h6000, 16'h4F00, 16'h50FF, 16'h53FF, 16'h4B00, 16'h6100, 16'h6200,
      16'h5400, 16'h1000};
    {srst, fp, sp, part} = 4'h8;
    void'($urandom(65153));
    repeat (12) @(posedge clk);
    srst <= 1'h0;
    // Reset values, including an unmapped offset
    foreach (rv[k]) rd(rv[k][15:8], rv[k][7:0]);
    // Every source code with fresh presence pins; code 3 leaves the previous one
    for (int k = 0; k < 4; k++) begin
      fp <= 1'($urandom);
      sp <= 1'($urandom);
      wr(fucr_pkg::ADDR_SRC_SEL, 8'(k));
      rd(fucr_pkg::ADDR_SRC_SEL, {2'h0, sp, fp, 2'h0, (k == 3) ? 2'h2 : 2'(k)});
    end
    // Store a word, disturb the window, fetch it back, then a blank entry
    w = $urandom;
    ix = 8'($urandom);
    for (int k = 0; k < 4; k++) wr(8'h50 + 8'(k), w[8 * k +: 8]);
    wr(fucr_pkg::ADDR_STORE, ix);
    wr(8'h51, ~w[15:8]);
    wr(fucr_pkg::ADDR_FETCH, ix);
    repeat (2) @(posedge clk);
    for (int k = 0; k < 4; k++) rd(8'h50 + 8'(k), w[8 * k +: 8]);
    wr(fucr_pkg::ADDR_FETCH, ix ^ 8'h01);
    repeat (2) @(posedge clk);
    rd(8'h52, 8'hFF);
    // Swap before any image is refused
    host_u.ctrl(8'h08);
    repeat (3) @(posedge clk);
    #1 `CHK("swap_failed", 1'h1, swap_failed)
    // Abort in mid-download restarts the index
    host_u.ctrl(8'h80);
    img(0, 8'h3C);
    img(1, 8'hC3);
    rd(8'h62, 8'h02);
    host_u.ctrl(8'h40);
    rd(8'h62, 8'h00);
    rd(8'h60, 8'h00);
    // Corrupted image: swap fails and nothing moves
    load(1'h1);
    host_u.ctrl(8'h08);
    repeat (4) @(posedge clk);
    #1 `CHK("fail state", {3'h7, part}, {swap_failed, image_complete, ~reboot_request,
      active_partition})
    // Good image: swap reboots and toggles the partition
    load(1'h0);
    host_u.ctrl(8'h08);
    for (n = 0; n < 20 && reboot_request !== 1'h1; n++) @(posedge clk);
    `CHK("reboot", 1'h1, reboot_request)
    part = ~part;
    rd(8'h60, {4'h0, part, 3'h0});
    repeat (4) @(posedge clk);
    `CHK("pending", 0, rq.size() + iq.size())
    final_report();
  end
endmodule : firmware_update_calib_regs_bench
